// ==== flash_status_pkg.sv ====
// Package with register map, field layout and timing constants for the flash status block
package flash_status_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_LOCK_STATE = 8'h01;
   localparam logic [7:0] IDX_PROT_STATE = 8'h03;
   localparam logic [7:0] IDX_CONFIG = 8'h04;
   localparam logic [7:0] IDX_PARAM_INDEX = 8'h02;
   localparam logic [11:0] ADDR_LOCK_STATE = 12'h004;
   localparam logic [11:0] ADDR_PARAM_INDEX = 12'h008;
   localparam logic [11:0] ADDR_PROT_STATE = 12'h00c;
   localparam logic [11:0] ADDR_CONFIG = 12'h010;
   // Nonvolatile source of the security byte
   localparam logic [23:0] SEC_BYTE_GADDR = 24'hff_fe0f;
   // Security register field layout
   localparam int KEY_MSB = 7;
   localparam int KEY_LSB = 6;
   localparam int LOCK_MSB = 1;
   localparam int LOCK_LSB = 0;
   localparam logic [1:0] KEY_ENABLED = 2'h2;
   localparam logic [1:0] LOCK_UNSECURED = 2'h2;
   localparam logic [7:0] SEC_ALL_SET = 8'hff;
   // Index register
   localparam int IDX_W = 3;
   // Status register fields
   localparam int OVR_BIT = 7;
   localparam int ACK_BIT = 0;
   // Configuration wait field
   localparam int WAIT_MSB = 3;
   localparam int WAIT_LSB = 2;
   localparam logic [1:0] WAIT_RESET = 2'h3;
   // Time for the read path to adopt a new wait count
   localparam int WAIT_SWITCH_NS = 40;
   localparam int CLK_NS = 10;
   localparam int WAIT_SWITCH_CYC = (WAIT_SWITCH_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_RUN = 2'b01
   } load_st_t;
endpackage

// ==== flash_security_status_regs.sv ====
// Flash security, parameter index and protection status registers on APB
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
module flash_security_status_regs
   import flash_status_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Nonvolatile security byte fetch
   input wire logic nv_valid,
   input wire logic [7:0] nv_byte,
   input wire logic nv_dbl_err,
   // Command engine status
   input wire logic cmd_idle,
   input wire logic backdoor_unlock,
   input wire logic override_active,
   // Block state outputs
   output logic backdoor_allowed,
   output logic chip_unsecured,
   output logic [IDX_W-1:0] param_index,
   output logic [1:0] read_wait_count,
   output logic wait_switch_done,
   output logic load_done
);
   import flash_status_pkg::*;

   typedef struct packed {
      load_st_t st;
      logic [7:0] sec;
      logic [IDX_W-1:0] idx;
      logic [1:0] wait_cfg;
      logic [1:0] wait_used;
      logic [7:0] sw_cnt;
      logic ovr;
      logic [31:0] rdata;
      logic ready;
      logic key_ok;
      logic unsec;
      logic ack;
      logic loaded;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   function automatic logic [31:0] read_mux(input state_t s, input logic [11:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         ADDR_LOCK_STATE: d = {24'h00_0000, s.sec};
         ADDR_PARAM_INDEX: d = {29'h0000_0000, s.idx};
         ADDR_PROT_STATE: d = {24'h00_0000, s.ovr, 6'h00, (s.sw_cnt == 8'h00)};
         ADDR_CONFIG: d = {28'h000_0000, s.wait_cfg, 2'h0};
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   logic setup;
   logic wr;
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && s_r.ready;

   always_comb begin
      s_nxt = s_r;
      s_nxt.ready = 1'b0;
      // Ready rises one cycle after setup; the answer is always two cycles
      if (setup) begin
         s_nxt.ready = 1'b1;
         s_nxt.rdata = read_mux(s_r, paddr);
      end
      if (psel && penable && s_r.ready) begin
         s_nxt.rdata = 32'h0000_0000;
      end
      case (s_r.st)
         ST_LOAD: begin
            if (nv_valid) begin
               s_nxt.sec = nv_dbl_err ? SEC_ALL_SET : nv_byte;
               s_nxt.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (backdoor_unlock) begin
               s_nxt.sec[LOCK_MSB:LOCK_LSB] = LOCK_UNSECURED;
            end
         end
         default: s_nxt.st = ST_LOAD;
      endcase
      s_nxt.ovr = override_active;
      // Count down first so that a fresh wait write below restarts the switch
      if (s_r.sw_cnt != 8'h00) begin
         s_nxt.sw_cnt = s_r.sw_cnt - 8'h01;
         if (s_r.sw_cnt == 8'h01) begin
            s_nxt.wait_used = s_r.wait_cfg;
         end
      end
      // Writes to security and status addresses fall through with no effect
      if (wr && pstrb[0]) begin
         if (paddr == ADDR_PARAM_INDEX) begin
            s_nxt.idx = pwdata[IDX_W-1:0];
         end
         // A wait change while a command runs is dropped entirely
         if (paddr == ADDR_CONFIG && cmd_idle &&
             pwdata[WAIT_MSB:WAIT_LSB] != s_r.wait_cfg) begin
            s_nxt.wait_cfg = pwdata[WAIT_MSB:WAIT_LSB];
            s_nxt.sw_cnt = 8'(WAIT_SWITCH_CYC);
         end
      end
      s_nxt.key_ok = (s_nxt.sec[KEY_MSB:KEY_LSB] == KEY_ENABLED);
      s_nxt.unsec = (s_nxt.sec[LOCK_MSB:LOCK_LSB] == LOCK_UNSECURED);
      // Acknowledge and load flags are registered so the pins come from flops
      s_nxt.ack = (s_nxt.sw_cnt == 8'h00);
      s_nxt.loaded = (s_nxt.st == ST_RUN);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{st: ST_LOAD, sec: SEC_ALL_SET, idx: '0, wait_cfg: WAIT_RESET,
                  wait_used: WAIT_RESET, sw_cnt: 8'h00, ovr: 1'b0, rdata: 32'h0000_0000,
                  ready: 1'b0, key_ok: 1'b0, unsec: 1'b0, ack: 1'b1, loaded: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.rdata;
   assign pready = s_r.ready;
   assign pslverr = 1'b0;
   assign backdoor_allowed = s_r.key_ok;
   assign chip_unsecured = s_r.unsec;
   assign param_index = s_r.idx;
   assign read_wait_count = s_r.wait_used;
   assign wait_switch_done = s_r.ack;
   assign load_done = s_r.loaded;

   AST_DBL_ERR_SECURES: assert property (@(posedge clk) disable iff (!arst_n)
      (s_r.st == ST_LOAD && nv_valid && nv_dbl_err) |=> (s_r.sec == SEC_ALL_SET))
      else $error("double-bit error did not secure");
   AST_LOAD_COPIES: assert property (@(posedge clk) disable iff (!arst_n)
      (s_r.st == ST_LOAD && nv_valid && !nv_dbl_err) |=> (s_r.sec == $past(nv_byte)))
      else $error("security byte not loaded");
   AST_SEC_RO: assert property (@(posedge clk) disable iff (!arst_n)
      (s_r.st == ST_RUN && !backdoor_unlock) |=> $stable(s_r.sec))
      else $error("security register changed");
   AST_KEY_DECODE: assert property (@(posedge clk) disable iff (!arst_n)
      backdoor_allowed == (s_r.sec[7:6] == 2'b10))
      else $error("backdoor decode wrong");
   AST_LOCK_DECODE: assert property (@(posedge clk) disable iff (!arst_n)
      chip_unsecured == (s_r.sec[1:0] == 2'b10))
      else $error("lock decode wrong");
   AST_UNLOCK_FORCE: assert property (@(posedge clk) disable iff (!arst_n)
      (s_r.st == ST_RUN && backdoor_unlock) |=> ##1 chip_unsecured)
      else $error("backdoor unlock did not unsecure");
   AST_IDX_HIGH_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
      (pready && !pwrite && paddr == ADDR_PARAM_INDEX) |-> (prdata[31:3] == 29'h0))
      else $error("index upper bits not zero");
   AST_OVR_FOLLOW: assert property (@(posedge clk) disable iff (!arst_n)
      override_active |=> s_r.ovr)
      else $error("override flag not shown");
   AST_ACK_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
      (wr && pstrb[0] && paddr == ADDR_CONFIG && cmd_idle && pwdata[3:2] != s_r.wait_cfg)
      |=> !wait_switch_done ##4 wait_switch_done)
      else $error("wait acknowledge timing wrong");
   AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (!arst_n)
      (wr && paddr == ADDR_CONFIG && !cmd_idle) |=> $stable(s_r.wait_cfg))
      else $error("wait field changed during command");
   AST_NO_ERR: assert property (@(posedge clk) disable iff (!arst_n)
      pready |-> !pslverr)
      else $error("error response raised");
   AST_READY_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
      pready |=> !pready)
      else $error("ready stood longer than one cycle");
   AST_IDX_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      (wr && pstrb[0] && paddr == ADDR_PARAM_INDEX) |=> (param_index == $past(pwdata[2:0])))
      else $error("index write not taken");
   AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      !wait_switch_done |=> (wait_switch_done || $stable(read_wait_count)))
      else $error("read wait count changed before acknowledge");
   AST_LOAD_STAYS: assert property (@(posedge clk) disable iff (!arst_n)
      load_done |=> load_done)
      else $error("load flag dropped");
endmodule
`default_nettype wire

// ==== flash_security_status_regs_tb.sv ====
// Self-checking bench for the flash security, index and status registers
`timescale 1ns/10ps
`default_nettype none
module flash_security_status_regs_tb;
   import flash_status_pkg::*;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, x;
   logic [3:0] pstrb;
   logic nv_valid, nv_dbl_err, cmd_idle, backdoor_unlock, override_active;
   logic backdoor_allowed, chip_unsecured, wait_switch_done, load_done;
   logic [7:0] nv_byte, sec;
   logic [IDX_W-1:0] param_index;
   logic [1:0] read_wait_count;
   int err_total = 0;
   int comparisons = 0;
   flash_security_status_regs u_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .nv_valid(nv_valid),
      .nv_byte(nv_byte), .nv_dbl_err(nv_dbl_err), .cmd_idle(cmd_idle),
      .backdoor_unlock(backdoor_unlock), .override_active(override_active),
      .backdoor_allowed(backdoor_allowed), .chip_unsecured(chip_unsecured),
      .param_index(param_index), .read_wait_count(read_wait_count),
      .wait_switch_done(wait_switch_done), .load_done(load_done));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic final_report();
      if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // Request held until pready is sampled; answer taken at that same edge
   // Ready is looked at mid-cycle, where it has settled, then the edge is taken
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic rdy;
      logic err;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(negedge clk);
      while (pready !== 1'b1) @(negedge clk);
      rd = prdata;
      rdy = pready;
      err = pslverr;
      @(posedge clk);
      chk("pready", 32'h1, 32'(rdy));
      chk("pslverr", 32'h0, 32'(err));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic do_reset(input logic [7:0] b, input logic e);
      arst_n <= 1'b0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      nv_valid <= 1'b1;
      nv_byte <= b;
      nv_dbl_err <= e;
      @(posedge clk);
      nv_valid <= 1'b0;
      nv_dbl_err <= 1'b0;
      repeat (3) @(posedge clk);
      sec = e ? SEC_ALL_SET : b;
      chk("load_done", 32'h1, 32'(load_done));
      chk("backdoor_allowed", 32'(sec[7:6] == KEY_ENABLED), 32'(backdoor_allowed));
      chk("chip_unsecured", 32'(sec[1:0] == LOCK_UNSECURED), 32'(chip_unsecured));
      apb(1'b0, ADDR_LOCK_STATE, 32'h0);
      chk("lock_state", 32'(sec), 32'(rd[7:0]));
      apb(1'b1, ADDR_LOCK_STATE, ~32'(sec));
      apb(1'b0, ADDR_LOCK_STATE, 32'h0);
      chk("lock_state_wr", 32'(sec), 32'(rd[7:0]));
   endtask
   initial begin
      #200000;
      err_total++;
      final_report();
   end
   initial begin
      {arst_n, psel, penable, pwrite, nv_valid, nv_dbl_err, backdoor_unlock} = '0;
      {paddr, pwdata, nv_byte, override_active} = '0;
      pstrb = 4'hf;
      cmd_idle = 1'b1;
      x = 32'h4;
      // Corner bytes first: unsecured with key enabled, then a double-bit fault
      for (int i = 0; i < 5; i++) begin
         x = xs(x);
         do_reset((i == 0) ? 8'h82 : (i == 2) ? 8'h7d : x[7:0], i == 1);
      end
      @(posedge clk);
      backdoor_unlock <= 1'b1;
      @(posedge clk);
      backdoor_unlock <= 1'b0;
      apb(1'b0, ADDR_LOCK_STATE, 32'h0);
      chk("unlock", 32'({sec[7:2], 2'b10}), 32'(rd[7:0]));
      for (int i = 0; i < 6; i++) begin
         x = (i == 0) ? 32'hffffffff : xs(x);
         apb(1'b1, ADDR_PARAM_INDEX, x);
         apb(1'b0, ADDR_PARAM_INDEX, 32'h0);
         chk("index", 32'(x[IDX_W-1:0]), rd);
         chk("param_index", 32'(x[IDX_W-1:0]), 32'(param_index));
      end
      for (int ov = 0; ov < 2; ov++) begin
         override_active <= ov[0];
         apb(1'b1, ADDR_PROT_STATE, 32'h0);
         apb(1'b0, ADDR_PROT_STATE, 32'h0);
         chk("prot_state", 32'({ov[0], 1'b1}), 32'({rd[7], rd[0]}));
      end
      apb(1'b1, 12'hff0, x);
      // A busy command engine must block the wait field update
      cmd_idle <= 1'b0;
      apb(1'b1, ADDR_CONFIG, 32'h8);
      repeat (6) @(posedge clk);
      chk("wait_busy", 32'h7, 32'({wait_switch_done, read_wait_count}));
      cmd_idle <= 1'b1;
      apb(1'b1, ADDR_CONFIG, 32'h4);
      @(posedge clk);
      chk("ack_low", 32'h3, 32'({wait_switch_done, read_wait_count}));
      for (int n = 0; n < 10 && wait_switch_done !== 1'b1; n++) @(posedge clk);
      chk("ack_high", 32'h5, 32'({wait_switch_done, read_wait_count}));
      apb(1'b0, ADDR_PROT_STATE, 32'h0);
      chk("ack_read", 32'h1, 32'(rd[0]));
      apb(1'b0, ADDR_CONFIG, 32'h0);
      chk("wait_field", 32'h1, 32'(rd[3:2]));
      final_report();
   end
endmodule
`default_nettype wire
